// *** common/scp_map.vh ***
// Function
// RL1: Port B decoded at 0061 for read and write; write bits 6-4 reserved.
// RL2: Port B write with bit 7 set clears timer 0 interrupt latch.
// RL3: Port B read bit 7 returns parity check latch.
// RL4: Port B read bit 6 returns channel check latch.
// RL5: Port B read bit 5 returns live timer 2 output level.
// RL6: Port B read bit 4 toggles on every memory refresh request.
// RL7: Port B bit 3 active-low channel check enable, power-on 1, read back.
// RL8: Port B bit 2 active-low parity check enable, power-on 1, read back.
// RL9: Port B bit 1 speaker data enable, power-on 0, read back.
// RL10: Port B bit 0 drives timer 2 gate, read back.
// RL11: Port 0070 bit 7 masks NMI when 1, write-only, power-on 1.
// RL12: Port 0070 bits 5-0 index config RAM; data moves through port 0071.
// RL13: Port 0092 bits 7,6 read/write; disk light on if either set.
// RL14: Port 0092 bit 4 read-only watchdog timeout status.
// RL15: Port 0092 bit 3 locks password area; cleared only by power-on.
// RL16: Port 0092 bit 1 drives high address gate; system reset clears it.
// RL17: Port 0092 bit 0 rising write pulses alternate reset 100-125 ns.
// RL18: Alternate reset at least 6.72 us after write; whole operation 13.4 us.
// RL19: Port 0092 bit 0 stays 1 until system reset or write of 0.
// RL20: Startup firmware reads bit 0: 0 cold boot, 1 protected-mode return.
// RL21: Error latches capture only while enabled, held clear while disabled.
`ifndef SCP_MAP_VH
`define SCP_MAP_VH

// ----------------------------------------
// Port addresses
// ----------------------------------------
`define SCP_ADDR_PORT_B     16'h0061
`define SCP_ADDR_INDEX      16'h0070
`define SCP_ADDR_DATA       16'h0071
`define SCP_ADDR_PORT_A     16'h0092

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCP_B_TMR0_CLR      7
`define SCP_B_PAR_LATCH     7
`define SCP_B_CHN_LATCH     6
`define SCP_B_TMR2_OUT      5
`define SCP_B_REFRESH       4
`define SCP_B_CHN_EN_N      3
`define SCP_B_PAR_EN_N      2
`define SCP_B_SPK_EN        1
`define SCP_B_TMR2_GATE     0
`define SCP_IDX_NMI_MASK    7
`define SCP_A_LIGHT_A       7
`define SCP_A_LIGHT_B       6
`define SCP_A_WDT           4
`define SCP_A_LOCK          3
`define SCP_A_GATE          1
`define SCP_A_HOT_RST       0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SCP_RST_B_CTRL      4'hc
`define SCP_RST_NMI_MASK    1'h1
`define SCP_RST_INDEX       6'h00

// ----------------------------------------
// Timing at 40 MHz
// ----------------------------------------
`define SCP_CLK_MHZ         40
`define SCP_PULSE_NS        100
`define SCP_DELAY_NS        6720
`define SCP_TOTAL_NS        13400
`define SCP_PULSE_CYC       ((`SCP_PULSE_NS * `SCP_CLK_MHZ + 999) / 1000)
`define SCP_DELAY_CYC       ((`SCP_DELAY_NS * `SCP_CLK_MHZ + 999) / 1000)
`define SCP_TOTAL_CYC       ((`SCP_TOTAL_NS * `SCP_CLK_MHZ) / 1000)

`endif

// *** rtl/scp_err_latch.v ***
`timescale 1ns/100ps
`include "scp_map.vh"

module scp_err_latch #(
  parameter N = 2
) (
  // Clock and reset
  input  wire         sys_clk,
  input  wire         clr,
  // Error sources
  input  wire [N-1:0] err_in,
  input  wire [N-1:0] enable_n,
  // Latched state
  output wire [N-1:0] latch
);

  reg [N-1:0] latch_reg;

  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_lat
      always @(posedge sys_clk) begin
        if (clr) begin
          latch_reg[i] <= 1'b0;
        end else if (enable_n[i]) begin
          latch_reg[i] <= 1'b0; // RL21
        end else if (err_in[i]) begin
          latch_reg[i] <= 1'b1; // RL21
        end
      end
    end
  endgenerate

  assign latch = latch_reg;

endmodule

// *** rtl/scp_hot_reset.v ***
`timescale 1ns/100ps
`include "scp_map.vh"

module scp_hot_reset #(
  parameter DELAY_CYC = `SCP_DELAY_CYC,
  parameter PULSE_CYC = `SCP_PULSE_CYC,
  parameter TOTAL_CYC = `SCP_TOTAL_CYC
) (
  // Clock and reset
  input  wire sys_clk,
  input  wire clr,
  // Control
  input  wire start,
  // Status
  output reg  busy_reg,
  output reg  pulse_reg
);

  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_WAIT  = 3'b010;
  localparam [2:0] ST_PULSE = 3'b100;

  reg [2:0]  state_reg;
  reg [10:0] cnt_reg;

  // Counter runs from the write for the whole operation so the pulse lands
  // at a fixed offset and the busy window covers the full sequence.
  always @(posedge sys_clk) begin
    if (clr) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 11'h000;
      busy_reg  <= 1'b0;
      pulse_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          cnt_reg <= 11'h000;
          if (start) begin
            state_reg <= ST_WAIT;
            busy_reg  <= 1'b1;
          end
        end
        ST_WAIT: begin
          cnt_reg <= cnt_reg + 11'h001;
          if (cnt_reg == DELAY_CYC[10:0] - 11'h002) begin
            state_reg <= ST_PULSE; // RL18
            pulse_reg <= 1'b1;     // RL17
          end
        end
        ST_PULSE: begin
          cnt_reg <= cnt_reg + 11'h001;
          if (cnt_reg == DELAY_CYC[10:0] + PULSE_CYC[10:0] - 11'h002) begin
            pulse_reg <= 1'b0; // RL17
          end
          if (cnt_reg == TOTAL_CYC[10:0] - 11'h002) begin
            state_reg <= ST_IDLE; // RL18
            busy_reg  <= 1'b0;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          busy_reg  <= 1'b0;
          pulse_reg <= 1'b0;
        end
      endcase
    end
  end

endmodule

// *** rtl/scp_top.v ***
`timescale 1ns/100ps
`include "scp_map.vh"

module scp_top #(
  parameter DELAY_CYC = `SCP_DELAY_CYC,
  parameter PULSE_CYC = `SCP_PULSE_CYC,
  parameter TOTAL_CYC = `SCP_TOTAL_CYC
) (
  // Clock and resets
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        por_n,

  // Processor I/O access
  input  wire [15:0] io_addr,
  input  wire        io_wr,
  input  wire        io_rd,
  input  wire [7:0]  io_wdata,
  output reg  [7:0]  io_rdata,
  output reg         io_rvalid,

  // Config RAM side
  output reg  [5:0]  cfg_ram_index,
  output reg         cfg_ram_wr,
  output reg         cfg_ram_rd,
  output reg  [7:0]  cfg_ram_wdata,
  input  wire [7:0]  cfg_ram_rdata,
  output reg         cfg_ram_lock,

  // Timer and speaker
  output reg         tmr0_clr,
  input  wire        tmr2_out,
  output reg         tmr2_gate,
  output reg         spk_data_en,
  input  wire        refresh_req,

  // Error checks and NMI
  input  wire        parity_err,
  input  wire        channel_err,
  output reg         nmi_mask,
  output reg         nmi_req,

  // System status
  input  wire        wdt_timeout,
  output reg         disk_light,
  output reg         high_address_line_gate,
  output reg         alt_cpu_reset,
  output reg         alt_reset_busy
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire sys_clr;
  wire por_clr;
  wire hit_b;
  wire hit_idx;
  wire hit_dat;
  wire hit_a;
  wire wr_b;
  wire wr_idx;
  wire wr_a;
  wire wr_dat;
  wire rd_dat;

  assign por_clr = ~por_n;
  // Power-on reset is a superset of system reset
  assign sys_clr = ~rst_n | ~por_n;

  assign hit_b   = (io_addr == `SCP_ADDR_PORT_B); // RL1
  assign hit_idx = (io_addr == `SCP_ADDR_INDEX);
  assign hit_dat = (io_addr == `SCP_ADDR_DATA);
  assign hit_a   = (io_addr == `SCP_ADDR_PORT_A);
  assign wr_b    = io_wr & hit_b;
  assign wr_idx  = io_wr & hit_idx;
  assign wr_a    = io_wr & hit_a;
  assign wr_dat  = io_wr & hit_dat;
  assign rd_dat  = io_rd & hit_dat;

  // ----------------------------------------
  // Port B control bits
  // ----------------------------------------
  localparam [3:0] B_CTRL_RST = `SCP_RST_B_CTRL;

  reg chn_en_n_reg;
  reg par_en_n_reg;
  reg refresh_tgl_reg;
  reg tmr2_out_reg;

  // Both check enables come up disabled so no stale error raises an NMI
  always @(posedge sys_clk) begin
    if (sys_clr) begin
      chn_en_n_reg <= B_CTRL_RST[`SCP_B_CHN_EN_N];
      par_en_n_reg <= B_CTRL_RST[`SCP_B_PAR_EN_N];
    end else if (wr_b) begin
      chn_en_n_reg <= io_wdata[`SCP_B_CHN_EN_N]; // RL7
      par_en_n_reg <= io_wdata[`SCP_B_PAR_EN_N]; // RL8
    end
  end

  // Bits 6-4 of a write are reserved and dropped
  always @(posedge sys_clk) begin
    if (sys_clr) begin
      spk_data_en <= 1'b0;
      tmr2_gate   <= 1'b0;
    end else if (wr_b) begin
      spk_data_en <= io_wdata[`SCP_B_SPK_EN];    // RL9
      tmr2_gate   <= io_wdata[`SCP_B_TMR2_GATE]; // RL10
    end
  end

  // Clear strobe toward the timer 0 interrupt latch
  always @(posedge sys_clk) begin
    if (sys_clr) begin
      tmr0_clr <= 1'b0;
    end else begin
      tmr0_clr <= wr_b & io_wdata[`SCP_B_TMR0_CLR]; // RL2
    end
  end

  // Refresh toggle and timer 2 output sample
  always @(posedge sys_clk) begin
    if (sys_clr) begin
      refresh_tgl_reg <= 1'b0;
      tmr2_out_reg    <= 1'b0;
    end else begin
      tmr2_out_reg <= tmr2_out; // RL5
      if (refresh_req) begin
        refresh_tgl_reg <= ~refresh_tgl_reg; // RL6
      end
    end
  end

  // ----------------------------------------
  // Parity and channel check latches
  // ----------------------------------------
  wire [1:0] err_latch;

  scp_err_latch #(
    .N (2)
  ) u_err (
    .sys_clk  (sys_clk),
    .clr      (sys_clr),
    .err_in   ({channel_err, parity_err}),
    .enable_n ({chn_en_n_reg, par_en_n_reg}),
    .latch    (err_latch)
  );

  // ----------------------------------------
  // Index and NMI mask
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (sys_clr) begin
      nmi_mask      <= `SCP_RST_NMI_MASK;
      cfg_ram_index <= `SCP_RST_INDEX;
    end else if (wr_idx) begin
      nmi_mask      <= io_wdata[`SCP_IDX_NMI_MASK]; // RL11
      cfg_ram_index <= io_wdata[5:0];               // RL12
    end
  end

  // Masked NMI; a latch that is set while masked fires once unmasked
  always @(posedge sys_clk) begin
    if (sys_clr) begin
      nmi_req <= 1'b0;
    end else begin
      nmi_req <= (|err_latch) & ~nmi_mask; // RL11
    end
  end

  // Data port strobes carry the held index to the config RAM
  always @(posedge sys_clk) begin
    if (sys_clr) begin
      cfg_ram_wr    <= 1'b0;
      cfg_ram_rd    <= 1'b0;
      cfg_ram_wdata <= 8'h00;
    end else begin
      cfg_ram_wr <= wr_dat; // RL12
      cfg_ram_rd <= rd_dat; // RL12
      if (wr_dat) begin
        cfg_ram_wdata <= io_wdata;
      end
    end
  end

  // ----------------------------------------
  // Port A
  // ----------------------------------------
  reg  light_a_reg;
  reg  light_b_reg;
  reg  hot_bit_reg;
  reg  wdt_reg;
  wire hot_rise;
  wire hot_start;
  wire seq_busy;
  wire seq_pulse;

  always @(posedge sys_clk) begin
    if (sys_clr) begin
      light_a_reg <= 1'b0;
      light_b_reg <= 1'b0;
    end else if (wr_a) begin
      light_a_reg <= io_wdata[`SCP_A_LIGHT_A]; // RL13
      light_b_reg <= io_wdata[`SCP_A_LIGHT_B]; // RL13
    end
  end

  always @(posedge sys_clk) begin
    if (sys_clr) begin
      high_address_line_gate <= 1'b0;
    end else if (wr_a) begin
      high_address_line_gate <= io_wdata[`SCP_A_GATE]; // RL16
    end
  end

  // Stored bit tells startup code a warm return from a cold start
  always @(posedge sys_clk) begin
    if (sys_clr) begin
      hot_bit_reg <= 1'b0;
    end else if (wr_a) begin
      hot_bit_reg <= io_wdata[`SCP_A_HOT_RST]; // RL19
    end
  end

  // Lock survives system reset; only power-on clears it, and a write of 0
  // cannot undo it, so software cannot reopen the password bytes.
  always @(posedge sys_clk) begin
    if (por_clr) begin
      cfg_ram_lock <= 1'b0;
    end else if (wr_a & io_wdata[`SCP_A_LOCK]) begin
      cfg_ram_lock <= 1'b1; // RL15
    end
  end

  always @(posedge sys_clk) begin
    if (sys_clr) begin
      wdt_reg <= 1'b0;
    end else begin
      wdt_reg <= wdt_timeout; // RL14
    end
  end

  always @(posedge sys_clk) begin
    if (sys_clr) begin
      disk_light <= 1'b0;
    end else begin
      disk_light <= light_a_reg | light_b_reg; // RL13
    end
  end

  // ----------------------------------------
  // Alternate processor reset
  // ----------------------------------------
  // Only a 0 to 1 change of the stored bit starts the sequence; a retrigger
  // inside the running window is ignored so the pulse is never stretched.
  assign hot_rise  = wr_a & io_wdata[`SCP_A_HOT_RST] & ~hot_bit_reg; // RL17
  assign hot_start = hot_rise & ~seq_busy;

  scp_hot_reset #(
    .DELAY_CYC (DELAY_CYC),
    .PULSE_CYC (PULSE_CYC),
    .TOTAL_CYC (TOTAL_CYC)
  ) u_hot (
    .sys_clk   (sys_clk),
    .clr       (sys_clr),
    .start     (hot_start),
    .busy_reg  (seq_busy),
    .pulse_reg (seq_pulse)
  );

  always @(posedge sys_clk) begin
    if (sys_clr) begin
      alt_cpu_reset  <= 1'b0;
      alt_reset_busy <= 1'b0;
    end else begin
      alt_cpu_reset  <= seq_pulse; // RL17
      alt_reset_busy <= seq_busy;  // RL18
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  wire [7:0] port_b_view;
  wire [7:0] port_a_view;
  wire [2:0] rd_sel;
  reg  [7:0] rd_mux;

  // Read layouts differ from write layouts; reserved read bits are 0
  assign port_b_view[`SCP_B_PAR_LATCH] = err_latch[0];    // RL3
  assign port_b_view[`SCP_B_CHN_LATCH] = err_latch[1];    // RL4
  assign port_b_view[`SCP_B_TMR2_OUT]  = tmr2_out_reg;    // RL5
  assign port_b_view[`SCP_B_REFRESH]   = refresh_tgl_reg; // RL6
  assign port_b_view[`SCP_B_CHN_EN_N]  = chn_en_n_reg;    // RL7
  assign port_b_view[`SCP_B_PAR_EN_N]  = par_en_n_reg;    // RL8
  assign port_b_view[`SCP_B_SPK_EN]    = spk_data_en;     // RL9
  assign port_b_view[`SCP_B_TMR2_GATE] = tmr2_gate;       // RL10

  assign port_a_view[`SCP_A_LIGHT_A] = light_a_reg;            // RL13
  assign port_a_view[`SCP_A_LIGHT_B] = light_b_reg;            // RL13
  assign port_a_view[5]              = 1'b0;
  assign port_a_view[`SCP_A_WDT]     = wdt_reg;                // RL14
  assign port_a_view[`SCP_A_LOCK]    = cfg_ram_lock;           // RL15
  assign port_a_view[2]              = 1'b0;
  assign port_a_view[`SCP_A_GATE]    = high_address_line_gate; // RL16
  assign port_a_view[`SCP_A_HOT_RST] = hot_bit_reg;            // RL19 RL20

  assign rd_sel = {hit_a, hit_dat, hit_b};

  // Hits are exclusive, so any other pattern is an unmapped read
  always @* begin
    case (rd_sel)
      3'b001: begin
        rd_mux = port_b_view;
      end
      3'b010: begin
        rd_mux = cfg_ram_rdata;
      end
      3'b100: begin
        rd_mux = port_a_view;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // Index port is write-only and reads back zero
  always @(posedge sys_clk) begin
    if (sys_clr) begin
      io_rdata  <= 8'h00;
      io_rvalid <= 1'b0;
    end else begin
      io_rvalid <= io_rd;
      if (io_rd) begin
        io_rdata <= rd_mux;
      end
    end
  end

endmodule

// *** testbench/scp_chk_sva.sv ***
`timescale 1ns/100ps
// ----
// Port timing checker
// ----
module scp_chk #(
  parameter int DELAY_CYC = 8,
  parameter int PULSE_CYC = 2,
  parameter int TOTAL_CYC = 16
) (
  // Clock and resets
  input logic        sys_clk,
  input logic        rst_n,
  input logic        por_n,
  // Processor access
  input logic [15:0] io_addr,
  input logic        io_wr,
  input logic        io_rd,
  input logic [7:0]  io_wdata,
  input logic        io_rvalid,
  // Controlled outputs
  input logic [5:0]  cfg_ram_index,
  input logic        cfg_ram_lock,
  input logic        tmr0_clr,
  input logic        tmr2_gate,
  input logic        spk_data_en,
  input logic        nmi_mask,
  input logic        disk_light,
  input logic        high_address_line_gate,
  input logic        alt_cpu_reset,
  input logic        alt_reset_busy
);
  localparam int D_UP = DELAY_CYC - 1;
  localparam int T_LO = TOTAL_CYC - 4;
  localparam int T_HI = TOTAL_CYC;
  wire wb = io_wr && io_addr == 16'h0061;
  wire wi = io_wr && io_addr == 16'h0070;
  wire wa = io_wr && io_addr == 16'h0092;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n || !por_n);

  property p_rd_answer; io_rd |=> io_rvalid; endproperty
  property p_tmr0_clr; wb && io_wdata[7] |=> tmr0_clr; endproperty
  property p_b_ctrl;
    wb |=> tmr2_gate == $past(io_wdata[0]) && spk_data_en == $past(io_wdata[1]);
  endproperty
  property p_index;
    wi |=> nmi_mask == $past(io_wdata[7]) && cfg_ram_index == $past(io_wdata[5:0]);
  endproperty
  property p_light; wa ##1 !wa |=> disk_light == |$past(io_wdata[7:6], 2); endproperty
  property p_gate; wa |=> high_address_line_gate == $past(io_wdata[1]); endproperty
  // Only power-on may clear the lock, so system reset must not mask this check
  property p_lock;
    disable iff (!por_n) cfg_ram_lock || (wa && io_wdata[3]) |=> cfg_ram_lock;
  endproperty
  property p_pulse; $rose(alt_cpu_reset) |-> ##PULSE_CYC $fell(alt_cpu_reset); endproperty
  property p_delay; $rose(alt_reset_busy) |-> ##D_UP $rose(alt_cpu_reset); endproperty
  property p_total; $rose(alt_reset_busy) |-> ##[T_LO:T_HI] !alt_reset_busy; endproperty

  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  a_tmr0_clr: assert property (p_tmr0_clr) else $error("timer clear missing");
  a_b_ctrl: assert property (p_b_ctrl) else $error("port b control wrong");
  a_index: assert property (p_index) else $error("index or mask wrong");
  a_light: assert property (p_light) else $error("disk light wrong");
  a_gate: assert property (p_gate) else $error("address gate wrong");
  a_lock: assert property (p_lock) else $error("lock dropped");
  a_pulse: assert property (p_pulse) else $error("reset pulse width wrong");
  a_delay: assert property (p_delay) else $error("reset delay wrong");
  a_total: assert property (p_total) else $error("reset length wrong");

  c_pulse: cover property ($fell(alt_cpu_reset));
  c_clear: cover property (wb && io_wdata[7]);
  c_data: cover property (io_rd && io_addr == 16'h0071);
endmodule

bind scp_top scp_chk #(
  .DELAY_CYC(DELAY_CYC),
  .PULSE_CYC(PULSE_CYC),
  .TOTAL_CYC(TOTAL_CYC)
) u_scp_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .por_n(por_n), .io_addr(io_addr),
  .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rvalid(io_rvalid),
  .cfg_ram_index(cfg_ram_index), .cfg_ram_lock(cfg_ram_lock), .tmr0_clr(tmr0_clr),
  .tmr2_gate(tmr2_gate), .spk_data_en(spk_data_en), .nmi_mask(nmi_mask),
  .disk_light(disk_light), .high_address_line_gate(high_address_line_gate),
  .alt_cpu_reset(alt_cpu_reset), .alt_reset_busy(alt_reset_busy)
);

// *** testbench/scp_cfg_ram_model.sv ***
`timescale 1ns/100ps
// ----
// Clock/config RAM partner
// ----
module scp_cfg_ram_model (
  // Clock
  input  logic       sys_clk,
  // Strobes from the ports
  input  logic [5:0] cfg_ram_index,
  input  logic       cfg_ram_wr,
  input  logic [7:0] cfg_ram_wdata,
  // Read data
  output logic [7:0] cfg_ram_rdata
);
  logic [7:0] mem [0:63];
  // Cells start as the inverted index, so a read of the wrong cell shows
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = ~8'(i);
    end
  end
  always @(posedge sys_clk) begin
    if (cfg_ram_wr) begin
      mem[cfg_ram_index] <= cfg_ram_wdata;
    end
  end
  assign cfg_ram_rdata = mem[cfg_ram_index];
endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/100ps
module testbench;
  logic        sys_clk = 0;
  logic        rst_n = 0;
  logic        por_n = 0;
  logic [15:0] io_addr = 16'h0000;
  logic        io_wr = 0;
  logic        io_rd = 0;
  logic [7:0]  io_wdata = 8'h00;
  logic        tmr2_out = 0;
  logic        refresh_req = 0;
  logic        parity_err = 0;
  logic        channel_err = 0;
  logic        wdt_timeout = 0;
  wire  [7:0]  io_rdata, cfg_ram_wdata, cfg_ram_rdata;
  wire  [5:0]  cfg_ram_index;
  wire         io_rvalid, cfg_ram_wr, cfg_ram_lock, tmr0_clr, tmr2_gate, spk_data_en;
  wire         nmi_mask, nmi_req, disk_light, hgate, alt_cpu_reset, alt_reset_busy;
  wire         cfg_ram_rd;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          n;

  scp_top #(.DELAY_CYC(8), .PULSE_CYC(2), .TOTAL_CYC(16)) u_scp_top (
    .sys_clk(sys_clk), .rst_n(rst_n), .por_n(por_n), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_rvalid(io_rvalid), .cfg_ram_index(cfg_ram_index), .cfg_ram_wr(cfg_ram_wr),
    .cfg_ram_rd(cfg_ram_rd), .cfg_ram_wdata(cfg_ram_wdata), .cfg_ram_rdata(cfg_ram_rdata),
    .cfg_ram_lock(cfg_ram_lock), .tmr0_clr(tmr0_clr), .tmr2_out(tmr2_out),
    .tmr2_gate(tmr2_gate), .spk_data_en(spk_data_en), .refresh_req(refresh_req),
    .parity_err(parity_err), .channel_err(channel_err), .nmi_mask(nmi_mask),
    .nmi_req(nmi_req), .wdt_timeout(wdt_timeout), .disk_light(disk_light),
    .high_address_line_gate(hgate), .alt_cpu_reset(alt_cpu_reset),
    .alt_reset_busy(alt_reset_busy)
  );

  scp_cfg_ram_model u_scp_cfg_ram_model (
    .sys_clk(sys_clk), .cfg_ram_index(cfg_ram_index), .cfg_ram_wr(cfg_ram_wr),
    .cfg_ram_wdata(cfg_ram_wdata), .cfg_ram_rdata(cfg_ram_rdata)
  );

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ----
  // Access tasks
  // ----
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Each access starts a negedge later, so strobes are never set and cleared at once
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1;
    @(negedge sys_clk);
    io_wr = 0;
  endtask

  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    io_addr = a;
    io_rd = 1;
    @(negedge sys_clk);
    io_rd = 0;
    check("rvalid", 8'(io_rvalid), 8'h01);
    check($sformatf("read %h", a), io_rdata, exp);
  endtask

  task automatic wait_out(input bit busy, input logic lvl, output int cnt);
    cnt = 0;
    while ((busy ? alt_reset_busy : alt_cpu_reset) !== lvl) begin
      @(negedge sys_clk);
      cnt++;
      if (cnt == 40) begin
        bad_count++;
        stop_test();
      end
    end
  endtask

  // ----
  // Scenarios
  // ----
  initial begin
    repeat (16) @(negedge sys_clk);
    rst_n = 1;
    por_n = 1;
    rdc(16'h0061, 8'h0c);
    rdc(16'h0070, 8'h00);
    rdc(16'h0080, 8'h00);
    check("nmi_mask", 8'(nmi_mask), 8'h01);
    wr(16'h0061, 8'hf3);
    check("tmr0_clr", 8'(tmr0_clr), 8'h01);
    check("spk_gate", 8'({spk_data_en, tmr2_gate}), 8'h03);
    rdc(16'h0061, 8'h03);
    check("tmr0_clr", 8'(tmr0_clr), 8'h00);
    parity_err = 1;
    channel_err = 1;
    tmr2_out = 1;
    @(negedge sys_clk);
    parity_err = 0;
    channel_err = 0;
    rdc(16'h0061, 8'he3);
    check("nmi_req", 8'(nmi_req), 8'h00);
    wr(16'h0070, 8'h05);
    @(negedge sys_clk);
    check("nmi_req", 8'(nmi_req), 8'h01);
    wr(16'h0061, 8'h0c);
    rdc(16'h0061, 8'h2c);
    parity_err = 1;
    @(negedge sys_clk);
    parity_err = 0;
    rdc(16'h0061, 8'h2c);
    repeat (3) begin
      refresh_req = 1;
      @(negedge sys_clk);
      refresh_req = 0;
      @(negedge sys_clk);
    end
    rdc(16'h0061, 8'h3c);
    wr(16'h0070, 8'h2a);
    check("index", 8'(cfg_ram_index), 8'h2a);
    wr(16'h0071, 8'h5a);
    @(negedge sys_clk);
    rdc(16'h0071, 8'h5a);
    check("cfg_ram_rd", 8'(cfg_ram_rd), 8'h01);
    wr(16'h0070, 8'h81);
    rdc(16'h0071, 8'hfe);
    wdt_timeout = 1;
    wr(16'h0092, 8'hff);
    wait_out(0, 1, n);
    check("reset_delay", 8'(n), 8'h08);
    wait_out(0, 0, n);
    check("reset_width", 8'(n), 8'h02);
    check("port_a_out", 8'({disk_light, hgate, cfg_ram_lock}), 8'h07);
    wait_out(1, 0, n);
    check("reset_total", 8'(n), 8'h06);
    rdc(16'h0092, 8'hdb);
    wr(16'h0092, 8'h02);
    rdc(16'h0092, 8'h1a);
    check("disk_light", 8'(disk_light), 8'h00);
    rst_n = 0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1;
    rdc(16'h0092, 8'h18);
    por_n = 0;
    repeat (2) @(negedge sys_clk);
    por_n = 1;
    rdc(16'h0092, 8'h10);
    check("nmi_mask", 8'(nmi_mask), 8'h01);
    stop_test();
  end
endmodule
